// File: design/erf_feature_reg.sv
// error record feature register: read-only 64-bit capability word
//
// Behaviour
// - With the extension flag set, bits 50, 49, 48 report recoverable, unrecoverable, uncontainable recording.
// - Bits 47:32 hold an implementation value, and bits 50:48 too when the extension flag is clear.
// - Bit 31 is the extension flag, only with version 1.1, else it reads zero.
// - Bits 30:26 always read zero.
// - Bits 25:24 give timestamp support: none, generic timebase or own timebase.
// - Bits 23:22 give critical interrupt support: none, always on, or controlled.
// - Bits 21:20 give common fault injection support: absent or present.
// - Bits 19:18 give the overwrite policy and read zero without a counter model.
// - Policy 00 keeps the first syndrome and sets overflow on counter wrap or without counter.
// - Policy 01 overwrites unless overflow is already set, and sets overflow on wrap.
// - Bits 17:16 give deferred interrupt control when recovery interrupts exist, else zero.
// - Bit 15 gives repeat plus other counter when a counter model exists, else zero.
// - Bits 14:12 give the counter model: none, 8-bit or 16-bit.
// - Bits 11:10 give corrected fault interrupt control when fault interrupts exist, else zero.
// - The register is 64-bit read-only at record base plus 64 times the record index.
`timescale 1ns/1ps
module erf_feature_reg
    import erf_pkg::*;
#(
    parameter int unsigned NUM_RECORDS     = 1,
    parameter logic        ARCH_V11        = 1'b1,
    parameter logic        FEAT_EXT        = 1'b1,
    parameter logic        CAP_RECOVERABLE = 1'b1,
    parameter logic        CAP_UNRECOVER   = 1'b1,
    parameter logic        CAP_UNCONTAIN   = 1'b0,
    parameter logic [2:0]  IMPL_UPPER      = 3'h0,
    parameter logic [15:0] IMPL_CONTROLS   = 16'h0000,
    parameter logic [1:0]  TSTAMP_SUPPORT  = ERF_TSTAMP_GENERIC,
    parameter logic [1:0]  CRIT_SUPPORT    = ERF_CRIT_CTRL,
    parameter logic [1:0]  FINS_SUPPORT    = ERF_FINS_NONE,
    parameter logic [1:0]  OVWR_POLICY     = ERF_OVWR_KEEP,
    parameter logic        RECOVERY_IRQ    = 1'b1,
    parameter logic [1:0]  DEFIRQ_CTRL     = ERF_IRQ_SHARED,
    parameter logic        REPEAT_CNT      = 1'b0,
    parameter logic [2:0]  CNT_MODEL       = ERF_CNTM_16B,
    parameter logic        FAULT_IRQ       = 1'b1,
    parameter logic [1:0]  CORIRQ_CTRL     = ERF_IRQ_SHARED
) (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // read port
    input  wire erf_rd_req_t rd_req_i,
    output erf_rd_rsp_t      rd_rsp_o,
    // write port, ignored
    input  wire logic        wr_valid_i,
    input  wire logic [63:0] wr_data_i,
    output logic             wr_ready_o
);

    // ------------------------------------------------------------
    // fixed capability record
    // ------------------------------------------------------------
    localparam erf_caps_t CAPS = '{
        arch_v11:                    ARCH_V11,
        feature_extension_flag:      FEAT_EXT,
        recoverable_recording_cap:   CAP_RECOVERABLE,
        unrecoverable_recording_cap: CAP_UNRECOVER,
        uncontainable_recording_cap: CAP_UNCONTAIN,
        impl_upper:                  IMPL_UPPER,
        impl_controls:               IMPL_CONTROLS,
        timestamp_support:           TSTAMP_SUPPORT,
        critical_irq_support:        CRIT_SUPPORT,
        fault_insertion_support:     FINS_SUPPORT,
        corrected_overwrite_policy:  OVWR_POLICY,
        recovery_irq_present:        RECOVERY_IRQ,
        deferred_recovery_irq_ctrl:  DEFIRQ_CTRL,
        repeat_counter_present:      REPEAT_CNT,
        counter_model:               CNT_MODEL,
        fault_irq_present:           FAULT_IRQ,
        corrected_fault_irq_ctrl:    CORIRQ_CTRL
    };

    logic [ERF_REG_W-1:0] feature_word;
    logic                 addr_hit;
    erf_top_state_t       st_reg;
    erf_top_state_t       st_next;

    // ------------------------------------------------------------
    // word packing and decode
    // ------------------------------------------------------------
    erf_field_pack u_pack (
        .caps_i (CAPS),
        .word_o (feature_word)
    );

    erf_addr_decode #(
        .NUM_RECORDS (NUM_RECORDS)
    ) u_dec (
        .req_i (rd_req_i),
        .hit_o (addr_hit)
    );

    // ------------------------------------------------------------
    // read answer, one cycle after request
    // ------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        if (rd_req_i.valid) begin
            st_next.state = ERF_ANSWER;
            st_next.hit   = addr_hit;
            st_next.data  = addr_hit ? feature_word : ERF_RESET_VALUE;
        end else begin
            st_next.state = ERF_IDLE;
            st_next.hit   = 1'b0;
            st_next.data  = ERF_RESET_VALUE;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            st_reg.state <= ERF_IDLE;
            st_reg.hit   <= 1'b0;
            st_reg.data  <= ERF_RESET_VALUE;
        end else begin
            st_reg <= st_next;
        end
    end

    always_comb begin
        rd_rsp_o.valid = (st_reg.state == ERF_ANSWER);
        rd_rsp_o.hit   = st_reg.hit;
        rd_rsp_o.data  = st_reg.data;
    end

    // writes accepted and dropped; data never reaches the word
    assign wr_ready_o = 1'b1;

    logic unused_wr;
    assign unused_wr = wr_valid_i ^ (^wr_data_i);

endmodule

// File: design/erf_pkg.sv
// package: field layout, encodings and capability record of the error record feature register
package erf_pkg;

    // ------------------------------------------------------------
    // register geometry
    // ------------------------------------------------------------
    localparam int unsigned ERF_REG_W        = 64;
    localparam int unsigned ERF_RECORD_STRIDE = 64;
    localparam logic [11:0] ERF_FEATURE_OFS  = 12'h000;
    localparam int unsigned ERF_IDX_W        = 6;
    localparam logic [63:0] ERF_RESET_VALUE  = 64'h0000_0000_0000_0000;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int unsigned ERF_UNCONT_POS = 48;
    localparam int unsigned ERF_UNREC_POS  = 49;
    localparam int unsigned ERF_RECOV_POS  = 50;
    localparam int unsigned ERF_IMPL_LSB   = 32;
    localparam int unsigned ERF_IMPL_MSB   = 47;
    localparam int unsigned ERF_EXT_POS    = 31;
    localparam int unsigned ERF_RSV_LSB    = 26;
    localparam int unsigned ERF_RSV_MSB    = 30;
    localparam int unsigned ERF_TSTAMP_LSB = 24;
    localparam int unsigned ERF_CRIT_LSB   = 22;
    localparam int unsigned ERF_FINS_LSB   = 20;
    localparam int unsigned ERF_OVWR_LSB   = 18;
    localparam int unsigned ERF_DEFIRQ_LSB = 16;
    localparam int unsigned ERF_REPEAT_POS = 15;
    localparam int unsigned ERF_CNTM_LSB   = 12;
    localparam int unsigned ERF_CORIRQ_LSB = 10;

    // ------------------------------------------------------------
    // encodings
    // ------------------------------------------------------------
    localparam logic [1:0] ERF_TSTAMP_NONE    = 2'h0;
    localparam logic [1:0] ERF_TSTAMP_GENERIC = 2'h1;
    localparam logic [1:0] ERF_TSTAMP_IMPL    = 2'h2;
    localparam logic [1:0] ERF_CRIT_NONE      = 2'h0;
    localparam logic [1:0] ERF_CRIT_ALWAYS    = 2'h1;
    localparam logic [1:0] ERF_CRIT_CTRL      = 2'h2;
    localparam logic [1:0] ERF_FINS_NONE      = 2'h0;
    localparam logic [1:0] ERF_FINS_COMMON    = 2'h1;
    localparam logic [1:0] ERF_OVWR_KEEP      = 2'h0;
    localparam logic [1:0] ERF_OVWR_REPLACE   = 2'h1;
    localparam logic [1:0] ERF_IRQ_NONE       = 2'h0;
    localparam logic [1:0] ERF_IRQ_SHARED     = 2'h2;
    localparam logic [1:0] ERF_IRQ_SPLIT      = 2'h3;
    localparam logic [2:0] ERF_CNTM_NONE      = 3'h0;
    localparam logic [2:0] ERF_CNTM_8B        = 3'h2;
    localparam logic [2:0] ERF_CNTM_16B       = 3'h4;

    // ------------------------------------------------------------
    // capability record, fixed at build time
    // ------------------------------------------------------------
    typedef struct packed {
        logic        arch_v11;
        logic        feature_extension_flag;
        logic        recoverable_recording_cap;
        logic        unrecoverable_recording_cap;
        logic        uncontainable_recording_cap;
        logic [2:0]  impl_upper;
        logic [15:0] impl_controls;
        logic [1:0]  timestamp_support;
        logic [1:0]  critical_irq_support;
        logic [1:0]  fault_insertion_support;
        logic [1:0]  corrected_overwrite_policy;
        logic        recovery_irq_present;
        logic [1:0]  deferred_recovery_irq_ctrl;
        logic        repeat_counter_present;
        logic [2:0]  counter_model;
        logic        fault_irq_present;
        logic [1:0]  corrected_fault_irq_ctrl;
    } erf_caps_t;

    // read request and answer
    typedef struct packed {
        logic                 valid;
        logic [ERF_IDX_W-1:0] index;
        logic [11:0]          offset;
    } erf_rd_req_t;

    typedef struct packed {
        logic                 valid;
        logic                 hit;
        logic [ERF_REG_W-1:0] data;
    } erf_rd_rsp_t;

    typedef enum logic [1:0] {
        ERF_IDLE,
        ERF_ANSWER
    } erf_state_t;

    typedef struct packed {
        erf_state_t           state;
        logic                 hit;
        logic [ERF_REG_W-1:0] data;
    } erf_top_state_t;

endpackage

// File: design/erf_field_pack.sv
// combinational packing of the capability record into the 64-bit feature word
`timescale 1ns/1ps
module erf_field_pack
    import erf_pkg::*;
(
    // capability record
    input  wire erf_caps_t      caps_i,
    // packed word
    output logic [ERF_REG_W-1:0] word_o
);

    logic counter_on;

    always_comb begin
        counter_on = (caps_i.counter_model != ERF_CNTM_NONE);
        word_o     = ERF_RESET_VALUE;
        // upper capability bits only architectural with extension
        if (caps_i.feature_extension_flag && caps_i.arch_v11) begin
            word_o[ERF_RECOV_POS]  = caps_i.recoverable_recording_cap;
            word_o[ERF_UNREC_POS]  = caps_i.unrecoverable_recording_cap;
            word_o[ERF_UNCONT_POS] = caps_i.uncontainable_recording_cap;
        end else begin
            word_o[ERF_RECOV_POS:ERF_UNCONT_POS] = caps_i.impl_upper;
        end
        word_o[ERF_IMPL_MSB:ERF_IMPL_LSB] = caps_i.impl_controls;
        word_o[ERF_EXT_POS] = caps_i.arch_v11 & caps_i.feature_extension_flag;
        word_o[ERF_RSV_MSB:ERF_RSV_LSB] = 5'h0;
        word_o[ERF_TSTAMP_LSB+:2] = caps_i.timestamp_support;
        word_o[ERF_CRIT_LSB+:2]   = caps_i.critical_irq_support;
        word_o[ERF_FINS_LSB+:2]   = caps_i.fault_insertion_support;
        if (counter_on) begin
            word_o[ERF_OVWR_LSB+:2] = caps_i.corrected_overwrite_policy;
            word_o[ERF_REPEAT_POS]  = caps_i.repeat_counter_present;
        end
        if (caps_i.recovery_irq_present) begin
            word_o[ERF_DEFIRQ_LSB+:2] = caps_i.deferred_recovery_irq_ctrl;
        end
        word_o[ERF_CNTM_LSB+:3] = caps_i.counter_model;
        if (caps_i.fault_irq_present) begin
            word_o[ERF_CORIRQ_LSB+:2] = caps_i.corrected_fault_irq_ctrl;
        end
    end

endmodule

// File: design/erf_addr_decode.sv
// decode of a byte offset from the record base, 64 times the record index, onto the feature register
`timescale 1ns/1ps
module erf_addr_decode
    import erf_pkg::*;
#(
    parameter int unsigned NUM_RECORDS = 1
) (
    // request
    input  wire erf_rd_req_t req_i,
    // decode
    output logic             hit_o
);

    logic [17:0] target;

    always_comb begin
        target = 18'(ERF_FEATURE_OFS) + 18'(ERF_RECORD_STRIDE) * 18'(req_i.index);
        hit_o  = req_i.valid && (18'(req_i.offset) == target)
                 && (32'(req_i.index) < NUM_RECORDS);
    end

endmodule

// File: sim/erf_feature_checker.sv
// concurrent checks on the feature register ports
`timescale 1ns/1ps
module erf_feature_checker
    import erf_pkg::*;
#(
    parameter int unsigned NUM_RECORDS = 1
) (
    // clock and reset
    input wire logic        clk_i,
    input wire logic        rst_n_i,
    // ports watched
    input wire erf_rd_req_t rd_req_i,
    input wire erf_rd_rsp_t rd_rsp_o,
    input wire logic        wr_valid_i,
    input wire logic [63:0] wr_data_i,
    input wire logic        wr_ready_o
);
    logic        map_hit;
    logic        seen_reg;
    logic [63:0] word_reg;
    assign map_hit = (rd_req_i.offset == (ERF_FEATURE_OFS + {rd_req_i.index, 6'h00}))
                     && (32'(rd_req_i.index) < NUM_RECORDS);
    // first word seen, later hits must repeat it
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            seen_reg <= 1'b0;
            word_reg <= 64'h0000_0000_0000_0000;
        end else if (rd_rsp_o.valid && rd_rsp_o.hit && !seen_reg) begin
            seen_reg <= 1'b1;
            word_reg <= rd_rsp_o.data;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    answer_follows_a: assert property (rd_req_i.valid |=> rd_rsp_o.valid)
        else $error("read answer missing one cycle after request");
    no_spurious_a: assert property (!rd_req_i.valid |=>
        !rd_rsp_o.valid && rd_rsp_o.data == 64'h0000_0000_0000_0000)
        else $error("answer without request");
    hit_decode_a: assert property (rd_req_i.valid && map_hit |=> rd_rsp_o.hit)
        else $error("feature address not decoded");
    miss_zero_a: assert property (rd_req_i.valid && !map_hit |=>
        !rd_rsp_o.hit && rd_rsp_o.data == 64'h0000_0000_0000_0000)
        else $error("unmapped read not zero");
    reserved_zero_a: assert property (rd_rsp_o.hit |-> rd_rsp_o.data[30:26] == 5'h00)
        else $error("reserved bits not zero");
    word_fixed_a: assert property (rd_rsp_o.hit && seen_reg |-> rd_rsp_o.data == word_reg)
        else $error("feature word changed");
    write_ready_a: assert property (wr_valid_i |-> wr_ready_o)
        else $error("write not accepted");
    counter_gate_a: assert property (rd_rsp_o.hit && rd_rsp_o.data[14:12] == 3'h0 |->
        rd_rsp_o.data[19:15] == 5'h00)
        else $error("overwrite or repeat set without counter");
    legal_codes_a: assert property (rd_rsp_o.hit |-> rd_rsp_o.data[25:24] != 2'h3 && !rd_rsp_o.data[21]
        && rd_rsp_o.data[14:12] inside {3'h0, 3'h2, 3'h4})
        else $error("reserved encoding read");
    cov_hit_c: cover property (rd_req_i.valid && map_hit ##1 rd_req_i.valid && map_hit);
    cov_miss_c: cover property (rd_req_i.valid && !map_hit);
    cov_write_c: cover property (wr_valid_i ##1 rd_req_i.valid && map_hit);
endmodule
bind erf_feature_reg erf_feature_checker #(.NUM_RECORDS(NUM_RECORDS)) u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .rd_req_i(rd_req_i), .rd_rsp_o(rd_rsp_o), .wr_valid_i(wr_valid_i), .wr_data_i(wr_data_i), .wr_ready_o(wr_ready_o));

// File: sim/testbench.sv
// self-checking bench for the feature register
`timescale 1ns/1ps
module testbench;
    import erf_pkg::*;
    localparam logic [15:0] IMPL   = 16'hA5C3;
    localparam logic [15:0] IMPL_B = 16'h3C5A;
    logic        clk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    erf_rd_req_t rd_req_i = '0;
    erf_rd_rsp_t rd_rsp_o;
    logic        wr_valid_i = 1'b0;
    logic [63:0] wr_data_i = 64'h0000_0000_0000_0000;
    logic        wr_ready_o;
    erf_rd_rsp_t rd_rsp_b;
    logic        wr_ready_b;
    int          mismatches = 0;
    int          comparisons = 0;
    logic [15:0] lfsr = 16'hDB8C;
    erf_feature_reg #(.NUM_RECORDS(4), .CAP_UNCONTAIN(1'b1), .IMPL_UPPER(3'h5), .IMPL_CONTROLS(IMPL),
        .TSTAMP_SUPPORT(ERF_TSTAMP_IMPL), .CRIT_SUPPORT(ERF_CRIT_ALWAYS), .FINS_SUPPORT(ERF_FINS_COMMON),
        .OVWR_POLICY(ERF_OVWR_REPLACE), .DEFIRQ_CTRL(ERF_IRQ_SPLIT), .REPEAT_CNT(1'b1), .CNT_MODEL(ERF_CNTM_8B),
        .CORIRQ_CTRL(ERF_IRQ_SPLIT)) DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .rd_req_i(rd_req_i),
        .rd_rsp_o(rd_rsp_o), .wr_valid_i(wr_valid_i), .wr_data_i(wr_data_i), .wr_ready_o(wr_ready_o));
    // gated build: no version 1.1, no counter model, no recovery or fault interrupts
    erf_feature_reg #(.NUM_RECORDS(4), .ARCH_V11(1'b0), .IMPL_UPPER(3'h5), .IMPL_CONTROLS(IMPL_B),
        .TSTAMP_SUPPORT(ERF_TSTAMP_NONE), .OVWR_POLICY(ERF_OVWR_REPLACE), .RECOVERY_IRQ(1'b0),
        .DEFIRQ_CTRL(ERF_IRQ_SPLIT), .REPEAT_CNT(1'b1), .CNT_MODEL(ERF_CNTM_NONE), .FAULT_IRQ(1'b0),
        .CORIRQ_CTRL(ERF_IRQ_SPLIT)) DUT_B (.clk_i(clk_i), .rst_n_i(rst_n_i), .rd_req_i(rd_req_i),
        .rd_rsp_o(rd_rsp_b), .wr_valid_i(wr_valid_i), .wr_data_i(wr_data_i), .wr_ready_o(wr_ready_b));
    always #10 clk_i = ~clk_i;
    function automatic logic [15:0] lfsr_next(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    // word from the chosen build parameters
    function automatic logic [63:0] exp_word();
        logic [63:0] w;
        w = 64'h0000_0000_0000_0000;
        w[50:48] = 3'b111 & {1'b1, 1'b1, 1'b1};
        w[47:32] = IMPL;
        w[31] = 1'b1;
        w[25:24] = 2'h2;
        w[23:22] = 2'h1;
        w[21:20] = 2'h1;
        w[19:18] = 2'h1;
        w[17:16] = 2'h3;
        w[15] = 1'b1;
        w[14:12] = 3'h2;
        w[11:10] = 2'h3;
        return w;
    endfunction
    // gated build: upper bits from the build value, gated fields and bit 31 zero
    function automatic logic [63:0] exp_word_b();
        logic [63:0] w;
        w = 64'h0000_0000_0000_0000;
        w[50:48] = 3'h5;
        w[47:32] = IMPL_B;
        w[23:22] = 2'h2;
        return w;
    endfunction
    task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // request stays up; answer checked one edge later
    task automatic issue(input logic [5:0] idx, input logic [11:0] ofs);
        logic hit;
        hit = (ofs == {idx, 6'h00}) && (idx < 6'd4);
        rd_req_i = '{valid: 1'b1, index: idx, offset: ofs};
        @(posedge clk_i);
        #1;
        check("rsp.valid", {63'h0, rd_rsp_o.valid}, 64'h0000_0000_0000_0001);
        check("rsp.hit", {63'h0, rd_rsp_o.hit}, {63'h0, hit});
        check("rsp.data", rd_rsp_o.data, hit ? exp_word() : 64'h0);
        check("alt.valid", {63'h0, rd_rsp_b.valid}, 64'h0000_0000_0000_0001);
        check("alt.data", rd_rsp_b.data, hit ? exp_word_b() : 64'h0);
    endtask
    task automatic idle(input string name);
        rd_req_i.valid = 1'b0;
        @(posedge clk_i);
        #1;
        check("idle rsp", {rd_rsp_o.valid, rd_rsp_o.hit, rd_rsp_o.data[61:0]}, 64'h0000_0000_0000_0000);
        $display("test %s done", name);
    endtask
    initial begin
        #(20 * 100000);
        mismatches++;
        conclude();
    end
    initial begin
        repeat (10) @(posedge clk_i);
        #1;
        check("reset rsp", {rd_rsp_o.valid, rd_rsp_o.hit, rd_rsp_o.data[61:0]}, 64'h0000_0000_0000_0000);
        check("wr_ready", {62'h0, wr_ready_o, wr_ready_b}, 64'h0000_0000_0000_0003);
        rst_n_i = 1'b1;
        @(posedge clk_i);
        #1;
        for (int i = 0; i < 4; i++) issue(6'(i), {6'(i), 6'h00});
        idle("records");
        issue(6'd4, 12'h100);
        issue(6'd1, 12'h060);
        issue(6'd0, 12'h040);
        issue(6'd63, 12'hFC0);
        idle("unmapped");
        for (int i = 0; i < 8; i++) begin
            lfsr = lfsr_next(lfsr);
            wr_valid_i = 1'b1;
            wr_data_i = {4{lfsr}};
            issue(6'(lfsr[1:0]), {4'h0, lfsr[1:0], 6'h00});
        end
        wr_valid_i = 1'b0;
        idle("writes");
        for (int i = 0; i < 300; i++) begin
            lfsr = lfsr_next(lfsr);
            issue(6'(lfsr[2:0]), lfsr[15] ? {3'h0, lfsr[2:0], 6'h00} : lfsr[14:3]);
        end
        idle("random");
        conclude();
    end
endmodule
